//--- logic/tpg_gate_ctrl.sv
/*
 Three-phase half-bridge gate control logic with an AHB-Lite register slave.
 Assumes all pins synchronous to hclk, one AHB-Lite master, single word
 transfers, and external pull-ups on the open-drain indicators.
*/
// How it works
// - Select low: six phase inputs act as independent high and low commands.
// - Select high: low command is the complement of each phase's high input.
// - Over-current mode low: drive cut for the present PWM cycle only.
// - Over-current mode high: only the tripped channel shuts down.
// - Gate enable turns on gate outputs and amplifiers; buck enable separate.
// - Each phase takes a high-side and low-side command input.
// - Over-current and over-temperature drive an open-drain warning pin.
// - Faults drive a separate open-drain fault pin.
// - Gain select low gives 10V/V, high gives 40V/V.
// - Calibration shorts amplifier inputs and turns all loads off.
// - Dead time separates complementary high and low gate transitions.
// - Power-good pin pulls low on regulator faults or buck disabled.
// - Each phase has its own high and low gate output.
`timescale 1ns/1ns
module tpg_gate_ctrl #(
   parameter int NPH = 3,
   parameter logic [7:0] DT_DEFAULT = tpg_pkg::DT_RESET
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic phase_a_high_cmd,
   input wire logic phase_a_low_cmd,
   input wire logic phase_b_high_cmd,
   input wire logic phase_b_low_cmd,
   input wire logic phase_c_high_cmd,
   input wire logic phase_c_low_cmd,
   input wire logic [2:0] overcurrent_detect,
   input wire logic overtemp_warn,
   input wire logic fault_detect,
   input wire logic regulator_low,
   output logic phase_a_high_gate,
   output logic phase_a_low_gate,
   output logic phase_b_high_gate,
   output logic phase_b_low_gate,
   output logic phase_c_high_gate,
   output logic phase_c_low_gate,
   output logic amp_enable,
   output logic amp_gain_sel,
   output logic amp_input_short,
   output logic buck_enable,
   output logic warn_indicator_n_o,
   output logic warn_indicator_n_oe,
   output logic fault_indicator_n_o,
   output logic fault_indicator_n_oe,
   output logic regulator_good_n_o,
   output logic regulator_good_n_oe,
   output logic irq
);

   // All state of the module in one struct
   typedef struct packed {
      tpg_pkg::tpg_chan_type [NPH-1:0] ch;
      tpg_pkg::tpg_pair_type [NPH-1:0] cmd_q;
      logic [6:0] ctrl;
      logic [tpg_pkg::EV_WIDTH-1:0] status;
      logic [tpg_pkg::EV_WIDTH-1:0] mask;
      logic [7:0] dt;
      logic dp_act;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic warn;
      logic fault;
      logic pgood_low;
      logic irq;
      logic amp_en;
      logic gain;
      logic cal;
      logic buck;
   } tpg_state_type;

   tpg_state_type state_r;
   tpg_state_type state_nxt;
   tpg_pkg::tpg_pair_type [NPH-1:0] cmd_in;

   // Gather the phase inputs into one pair per phase
   always_comb begin
      cmd_in[0] = '{high: phase_a_high_cmd, low: phase_a_low_cmd};
      cmd_in[1] = '{high: phase_b_high_cmd, low: phase_b_low_cmd};
      cmd_in[2] = '{high: phase_c_high_cmd, low: phase_c_low_cmd};
   end

   // Next-state logic for the bus slave, events and each half-bridge
   always_comb begin
      logic addr_phase;
      logic rd_status;
      logic [tpg_pkg::EV_WIDTH-1:0] ev;
      logic gate_on;
      logic three_pwm;
      logic oc_shut;
      logic want_h;
      logic want_l;
      logic oc;
      addr_phase = 1'b0;
      rd_status = 1'b0;
      ev = '0;
      gate_on = 1'b0;
      three_pwm = 1'b0;
      oc_shut = 1'b0;
      want_h = 1'b0;
      want_l = 1'b0;
      oc = 1'b0;
      state_nxt = state_r;

      // Address phase: latch for the data phase, no wait states
      addr_phase = hsel && hready && htrans[1];
      state_nxt.dp_act = addr_phase;
      state_nxt.dp_write = addr_phase && hwrite;
      state_nxt.dp_addr = haddr[7:0];
      rd_status = addr_phase && !hwrite &&
                  haddr[7:0] == tpg_pkg::ADDR_STATUS;
      // Read data prepared here so it is registered for the data phase
      if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            tpg_pkg::ADDR_CTRL: state_nxt.rdata = {25'h0, state_r.ctrl};
            tpg_pkg::ADDR_STATUS: state_nxt.rdata = {26'h0, state_r.status};
            tpg_pkg::ADDR_MASK: state_nxt.rdata = {26'h0, state_r.mask};
            tpg_pkg::ADDR_STATE: state_nxt.rdata = {26'h0,
               state_r.ch[2].gate, state_r.ch[1].gate, state_r.ch[0].gate};
            tpg_pkg::ADDR_DEADTIME: state_nxt.rdata = {24'h0, state_r.dt};
            default: state_nxt.rdata = 32'h0;
         endcase
      end
      // Clear-shutdown is a self-clearing strobe
      state_nxt.ctrl[tpg_pkg::CTRL_CLR_SHUT] = 1'b0;
      if (state_r.dp_act && state_r.dp_write) begin
         unique case (state_r.dp_addr)
            tpg_pkg::ADDR_CTRL: state_nxt.ctrl = hwdata[6:0];
            tpg_pkg::ADDR_MASK: state_nxt.mask = hwdata[5:0];
            tpg_pkg::ADDR_DEADTIME: state_nxt.dt = hwdata[7:0];
            default: ;
         endcase
      end

      gate_on = state_r.ctrl[tpg_pkg::CTRL_GATE_EN];
      three_pwm = state_r.ctrl[tpg_pkg::CTRL_THREE_PWM];
      oc_shut = state_r.ctrl[tpg_pkg::CTRL_OC_SHUTDOWN];
      state_nxt.amp_en = gate_on;
      state_nxt.buck = state_r.ctrl[tpg_pkg::CTRL_BUCK_EN];
      state_nxt.gain = state_r.ctrl[tpg_pkg::CTRL_GAIN_HIGH] ?
                       tpg_pkg::GAIN_40 : tpg_pkg::GAIN_10;
      state_nxt.cal = state_r.ctrl[tpg_pkg::CTRL_CAL];

      // Per-phase command path, protection and dead-time sequencer
      for (int i = 0; i < NPH; i++) begin
         state_nxt.cmd_q[i] = cmd_in[i];
         want_h = state_r.cmd_q[i].high;
         // Three-input mode derives the low side; else inputs are free
         want_l = three_pwm ? !state_r.cmd_q[i].high
                            : state_r.cmd_q[i].low;
         oc = overcurrent_detect[i];
         // Cycle-by-cycle: cut until the high command next rises
         if (!oc_shut && oc) begin
            state_nxt.ch[i].limited = 1'b1;
         end else if (cmd_in[i].high && !state_r.cmd_q[i].high) begin
            state_nxt.ch[i].limited = 1'b0;
         end
         // Shutdown mode latches only this channel off until cleared
         if (oc_shut && oc) begin
            state_nxt.ch[i].shut = 1'b1;
         end else if (state_r.ctrl[tpg_pkg::CTRL_CLR_SHUT] || !oc_shut) begin
            state_nxt.ch[i].shut = 1'b0;
         end
         // Conflicting commands resolve to both off
         if (want_h && want_l) begin
            want_h = 1'b0;
            want_l = 1'b0;
         end
         if (!gate_on || state_r.cal || state_r.ch[i].shut ||
             state_r.ch[i].limited || oc) begin
            want_h = 1'b0;
            want_l = 1'b0;
         end
         // Any change of conducting side passes through dead time
         unique case (state_r.ch[i].state)
            tpg_pkg::PH_OFF: begin
               if (want_h || want_l) begin
                  state_nxt.ch[i].state = tpg_pkg::PH_DEAD;
                  state_nxt.ch[i].pending_high = want_h;
                  state_nxt.ch[i].dead_cnt = state_r.dt;
               end
            end
            tpg_pkg::PH_HIGH: begin
               if (!want_h) begin
                  state_nxt.ch[i].state = tpg_pkg::PH_OFF;
               end
            end
            tpg_pkg::PH_LOW: begin
               if (!want_l) begin
                  state_nxt.ch[i].state = tpg_pkg::PH_OFF;
               end
            end
            tpg_pkg::PH_DEAD: begin
               if (!(want_h || want_l) ||
                   want_h != state_r.ch[i].pending_high) begin
                  state_nxt.ch[i].state = tpg_pkg::PH_OFF;
               end else if (state_r.ch[i].dead_cnt <= 8'h01) begin
                  state_nxt.ch[i].state = want_h ? tpg_pkg::PH_HIGH
                                                 : tpg_pkg::PH_LOW;
               end else begin
                  state_nxt.ch[i].dead_cnt = state_r.ch[i].dead_cnt - 8'h01;
               end
            end
         endcase
         // Gates come from the next state so they lag it by no cycle
         state_nxt.ch[i].gate.high =
            state_nxt.ch[i].state == tpg_pkg::PH_HIGH && want_h;
         state_nxt.ch[i].gate.low =
            state_nxt.ch[i].state == tpg_pkg::PH_LOW && want_l;
      end

      // Indicators and sticky events; set wins over read-clear
      state_nxt.warn = (|overcurrent_detect) || overtemp_warn;
      state_nxt.fault = fault_detect ||
                        (|{state_r.ch[2].shut, state_r.ch[1].shut,
                           state_r.ch[0].shut});
      state_nxt.pgood_low = regulator_low ||
                            !state_r.ctrl[tpg_pkg::CTRL_BUCK_EN];
      ev[tpg_pkg::EV_OC_A] = overcurrent_detect[0];
      ev[tpg_pkg::EV_OC_B] = overcurrent_detect[1];
      ev[tpg_pkg::EV_OC_C] = overcurrent_detect[2];
      ev[tpg_pkg::EV_OT] = overtemp_warn;
      ev[tpg_pkg::EV_FAULT] = fault_detect;
      ev[tpg_pkg::EV_PGOOD_LOST] = state_nxt.pgood_low && !state_r.pgood_low;
      state_nxt.status = (rd_status ? '0 : state_r.status) | ev;
      state_nxt.irq = |(state_nxt.status & state_nxt.mask);
   end

   // Single register stage for all state; reset holds every gate off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= '0;
         state_r.ctrl <= tpg_pkg::CTRL_RESET;
         state_r.mask <= tpg_pkg::MASK_RESET;
         state_r.dt <= DT_DEFAULT;
         state_r.pgood_low <= 1'b1;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state register; bus ready and response are tied to constants
   assign hrdata = state_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign phase_a_high_gate = state_r.ch[0].gate.high;
   assign phase_a_low_gate = state_r.ch[0].gate.low;
   assign phase_b_high_gate = state_r.ch[1].gate.high;
   assign phase_b_low_gate = state_r.ch[1].gate.low;
   assign phase_c_high_gate = state_r.ch[2].gate.high;
   assign phase_c_low_gate = state_r.ch[2].gate.low;
   assign amp_enable = state_r.amp_en;
   assign amp_gain_sel = state_r.gain;
   assign amp_input_short = state_r.cal;
   assign buck_enable = state_r.buck;
   // Open drain: pin pulled low by driving 0 with enable low
   assign warn_indicator_n_o = 1'b0;
   assign warn_indicator_n_oe = !state_r.warn;
   assign fault_indicator_n_o = 1'b0;
   assign fault_indicator_n_oe = !state_r.fault;
   assign regulator_good_n_o = 1'b0;
   assign regulator_good_n_oe = !state_r.pgood_low;
   assign irq = state_r.irq;
endmodule

//--- logic/tpg_pkg.sv
/*
 Package for the three-phase gate control block: register offsets, field
 positions, reset values, timing counts and the carrier structs.
 Assumes a 50 MHz hclk and an AHB-Lite master with 32-bit words.
*/
package tpg_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0C;
   localparam logic [7:0] ADDR_DEADTIME = 8'h10;
   // Control register fields
   localparam int CTRL_GATE_EN = 0;
   localparam int CTRL_THREE_PWM = 1;
   localparam int CTRL_OC_SHUTDOWN = 2;
   localparam int CTRL_GAIN_HIGH = 3;
   localparam int CTRL_CAL = 4;
   localparam int CTRL_BUCK_EN = 5;
   localparam int CTRL_CLR_SHUT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   // Status and mask fields: one bit per event
   localparam int EV_OC_A = 0;
   localparam int EV_OC_B = 1;
   localparam int EV_OC_C = 2;
   localparam int EV_OT = 3;
   localparam int EV_FAULT = 4;
   localparam int EV_PGOOD_LOST = 5;
   localparam int EV_WIDTH = 6;
   localparam logic [5:0] MASK_RESET = 6'h00;
   // Dead time: default printed figure in ns, counted in hclk cycles
   localparam int CLK_MHZ = 50;
   localparam int DEADTIME_NS = 100;
   localparam int DEADTIME_CYC = (DEADTIME_NS * CLK_MHZ + 999) / 1000;
   localparam int DT_WIDTH = 8;
   localparam logic [7:0] DT_RESET = DEADTIME_CYC[7:0];
   // Gain codes reported on the gain select output
   localparam logic GAIN_10 = 1'b0;
   localparam logic GAIN_40 = 1'b1;

   // One phase's pair of commands or gates
   typedef struct packed {
      logic high;
      logic low;
   } tpg_pair_type;

   typedef enum logic [1:0] {
      PH_OFF = 2'b00,
      PH_HIGH = 2'b01,
      PH_LOW = 2'b10,
      PH_DEAD = 2'b11
   } tpg_phase_type;

   // Per-phase state
   typedef struct packed {
      tpg_phase_type state;
      logic [7:0] dead_cnt;
      logic pending_high;
      logic shut;
      logic limited;
      tpg_pair_type gate;
   } tpg_chan_type;
endpackage

//--- sim/three_phase_gate_control_tb.sv
/*
 Self-checking bench: AHB-Lite tasks, one task per scenario.
 Assumes the host model on the PWM pins and the bound checker.
*/
`timescale 1ns/1ns
module three_phase_gate_control_tb;
   localparam logic [7:0] CT = tpg_pkg::ADDR_CTRL;
   localparam logic [7:0] ST = tpg_pkg::ADDR_STATUS;
   localparam logic [7:0] MK = tpg_pkg::ADDR_MASK;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] overcurrent_detect = 3'h0;
   logic overtemp_warn = 1'b0;
   logic fault_detect = 1'b0;
   logic regulator_low = 1'b0;
   logic three_mode = 1'b0;
   logic [5:0] want = 6'h00;
   logic [5:0] cmd;
   logic [31:0] hrdata, gates;
   logic hreadyout, hresp, irq, amp_enable, amp_gain_sel;
   logic amp_input_short, buck_enable;
   logic warn_indicator_n_o, warn_indicator_n_oe;
   logic fault_indicator_n_o, fault_indicator_n_oe;
   logic regulator_good_n_o, regulator_good_n_oe;
   logic phase_a_high_gate, phase_a_low_gate, phase_b_high_gate;
   logic phase_b_low_gate, phase_c_high_gate, phase_c_low_gate;
   logic phase_a_high_cmd, phase_a_low_cmd, phase_b_high_cmd;
   logic phase_b_low_cmd, phase_c_high_cmd, phase_c_low_cmd;
   wire hready;
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   // One slave, so its ready is the bus ready
   assign hready = hreadyout;
   assign {phase_c_high_cmd, phase_c_low_cmd, phase_b_high_cmd,
      phase_b_low_cmd, phase_a_high_cmd, phase_a_low_cmd} = cmd;
   assign gates = {26'h0, phase_c_high_gate, phase_c_low_gate,
      phase_b_high_gate, phase_b_low_gate, phase_a_high_gate,
      phase_a_low_gate};
   always #10 hclk = !hclk;
   tpg_gate_ctrl tpg_gate_ctrl_inst (.*);
   tpg_host_model tpg_host_model_inst (.hclk(hclk),
      .three_mode(three_mode), .want(want), .cmd(cmd));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // A hang ends here; the run needs well under 2000 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: pin %b not %b", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask
   task automatic oc_pulse;
      overcurrent_detect <= 3'h1;
      @(posedge hclk);
      overcurrent_detect <= 3'h0;
      idle(3);
   endtask
   task automatic t_regs;
      rdc(CT, 32'h0);
      rdc(tpg_pkg::ADDR_DEADTIME, {24'h0, tpg_pkg::DT_RESET});
      chk1(hreadyout, 1'b1);
      chk1(hresp, 1'b0);
      // Longer dead time reads back, then the default is put back
      wr(tpg_pkg::ADDR_DEADTIME, 32'h07);
      rdc(tpg_pkg::ADDR_DEADTIME, 32'h07);
      wr(tpg_pkg::ADDR_DEADTIME, {24'h0, tpg_pkg::DT_RESET});
      rdc(8'h20, 32'h0);
      wr(MK, 32'h1);
      rdc(MK, 32'h1);
      $display("regs done");
   endtask
   task automatic t_six;
      wr(CT, 32'h1);
      want <= 6'h26;
      idle(4);
      chk(gates, 32'h0);
      idle(10);
      chk(gates, 32'h26);
      rdc(tpg_pkg::ADDR_STATE, 32'h26);
      want <= 6'h31;
      idle(12);
      chk(gates, 32'h01);
      $display("six-input done");
   endtask
   task automatic t_three;
      three_mode <= 1'b1;
      wr(CT, 32'h3);
      want <= 6'h20;
      idle(12);
      chk(gates, 32'h25);
      want <= 6'h02;
      idle(12);
      chk(gates, 32'h16);
      three_mode <= 1'b0;
      wr(CT, 32'h1);
      $display("three-input done");
   endtask
   task automatic t_oc_limit;
      logic [31:0] x;
      idle(12);
      bus(1'b0, ST, 32'h0, x);
      oc_pulse();
      chk(gates, 32'h0);
      chk1(irq, 1'b1);
      wr(MK, 32'h0);
      idle(2);
      chk1(irq, 1'b0);
      wr(MK, 32'h1);
      rdc(ST, 32'h1);
      idle(2);
      chk1(irq, 1'b0);
      chk(gates, 32'h0);
      want <= 6'h00;
      idle(3);
      want <= 6'h02;
      idle(12);
      chk(gates, 32'h02);
      $display("cycle limit done");
   endtask
   task automatic t_oc_shut;
      wr(CT, 32'h5);
      want <= 6'h0A;
      idle(12);
      oc_pulse();
      chk(gates, 32'h08);
      chk1(fault_indicator_n_oe, 1'b0);
      want <= 6'h08;
      idle(3);
      want <= 6'h0A;
      idle(12);
      chk(gates, 32'h08);
      wr(CT, 32'h45);
      idle(12);
      chk(gates, 32'h0A);
      rdc(CT, 32'h5);
      $display("shutdown done");
   endtask
   task automatic t_amp;
      wr(CT, 32'h0D);
      idle(2);
      chk1(amp_gain_sel, tpg_pkg::GAIN_40);
      chk1(amp_enable, 1'b1);
      wr(CT, 32'h15);
      idle(3);
      chk(gates, 32'h0);
      chk1(amp_input_short, 1'b1);
      chk1(amp_gain_sel, tpg_pkg::GAIN_10);
      wr(CT, 32'h20);
      idle(3);
      chk(gates, 32'h0);
      chk1(amp_enable, 1'b0);
      chk1(buck_enable, 1'b1);
      chk1(regulator_good_n_oe, 1'b1);
      regulator_low <= 1'b1;
      idle(3);
      chk1(regulator_good_n_oe, 1'b0);
      regulator_low <= 1'b0;
      $display("amplifier done");
   endtask
   task automatic t_warn;
      overtemp_warn <= 1'b1;
      idle(3);
      chk1(warn_indicator_n_oe, 1'b0);
      overtemp_warn <= 1'b0;
      fault_detect <= 1'b1;
      idle(3);
      chk1(warn_indicator_n_oe, 1'b1);
      chk1(fault_indicator_n_oe, 1'b0);
      fault_detect <= 1'b0;
      $display("indicators done");
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_six();
      t_three();
      t_oc_limit();
      t_oc_shut();
      t_amp();
      t_warn();
      wrap_up();
   end
endmodule

//--- sim/tpg_gate_ctrl_checker.sv
/*
 Port checker for the gate control block.
 Assumes the default dead time of five cycles and one hclk domain.
*/
`timescale 1ns/1ns
module tpg_gate_ctrl_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] overcurrent_detect,
   input wire logic overtemp_warn,
   input wire logic fault_detect,
   input wire logic regulator_low,
   input wire logic phase_a_high_gate,
   input wire logic phase_a_low_gate,
   input wire logic phase_b_high_gate,
   input wire logic phase_b_low_gate,
   input wire logic phase_c_high_gate,
   input wire logic phase_c_low_gate,
   input wire logic amp_enable,
   input wire logic amp_input_short,
   input wire logic buck_enable,
   input wire logic warn_indicator_n_o,
   input wire logic warn_indicator_n_oe,
   input wire logic fault_indicator_n_o,
   input wire logic fault_indicator_n_oe,
   input wire logic regulator_good_n_o,
   input wire logic regulator_good_n_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [5:0] g;
   logic [3:0] off_cnt_r;
   assign g = {phase_c_high_gate, phase_c_low_gate, phase_b_high_gate,
      phase_b_low_gate, phase_a_high_gate, phase_a_low_gate};
   // Cycles phase A has had both gates off, saturating at 15
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) off_cnt_r <= 4'hF;
      else if (g[1] || g[0]) off_cnt_r <= 4'h0;
      else if (off_cnt_r != 4'hF) off_cnt_r <= off_cnt_r + 4'h1;
   end
   sequence gate_a_on;
      $rose(phase_a_high_gate) || $rose(phase_a_low_gate);
   endsequence
   shoot_thru_a:
      assert property (!(g[5] && g[4]) && !(g[3] && g[2]) && !(g[1] && g[0]))
      else $error("both gates of a phase on");
   gate_disable_a:
      assert property (!amp_enable && !$past(amp_enable) |-> g == 6'h00)
      else $error("gate on while disabled");
   calib_off_a:
      assert property (amp_input_short && $past(amp_input_short) |-> g == 6'h00)
      else $error("gate on during calibration");
   dead_time_a:
      assert property (gate_a_on |-> off_cnt_r >= 4'h4)
      else $error("dead time too short");
   oc_cut_a:
      assert property (overcurrent_detect[0] |=> g[1:0] == 2'h0)
      else $error("over-current did not cut phase A");
   warn_pin_a:
      assert property (|overcurrent_detect || overtemp_warn
         |-> ##[1:2] !warn_indicator_n_oe)
      else $error("warning pin not pulled low");
   fault_pin_a:
      assert property (fault_detect |-> ##[1:2] !fault_indicator_n_oe)
      else $error("fault pin not pulled low");
   pgood_pin_a:
      assert property (regulator_low || !buck_enable
         |-> ##[0:2] !regulator_good_n_oe)
      else $error("power good pin not pulled low");
   od_drive_a:
      assert property (!warn_indicator_n_o && !fault_indicator_n_o
         && !regulator_good_n_o)
      else $error("open-drain pin drives high");
endmodule
bind tpg_gate_ctrl tpg_gate_ctrl_checker tpg_gate_ctrl_checker_inst (.*);

//--- sim/tpg_host_model.sv
/*
 Host controller model driving the six PWM command pins.
 Assumes want holds the commanded levels {C.h,C.l,B.h,B.l,A.h,A.l}.
*/
`timescale 1ns/1ns
module tpg_host_model (
   input wire logic hclk,
   input wire logic three_mode,
   input wire logic [5:0] want,
   output logic [5:0] cmd
);
   logic flip = 1'b0;
   initial cmd = 6'h00;
   // Change the pins just after each rising edge
   always @(posedge hclk) begin
      flip <= !flip;
      for (int i = 0; i < 3; i++) begin
         cmd[2*i+1] <= want[2*i+1];
         // Low pins are unwired in three-input mode, so they wander
         cmd[2*i] <= three_mode ? flip : want[2*i];
      end
   end
endmodule
